// ### rtl/vcom_pkg.sv
// shared constants, types and helpers of the serial bridge
// assumes one 200 MHz core clock, no software registers
package vcom_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and serial timing
    localparam int          CLK_HZ         = 200_000_000;
    localparam int          MAX_BAUD       = 1_000_000;
    localparam int          DIV_W          = 16;
    localparam logic [15:0] MIN_BIT_CYCLES =
        16'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
    localparam int          DATA_W         = 8;
    localparam logic [3:0]  STOP_BIT_IDX   = 4'h9;
    localparam int          FIFO_DEPTH     = 32;

    ////////////////////////////////////////////////////////////////////////
    // status led blink half period
    localparam int BLINK_MS     = 250;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

    ////////////////////////////////////////////////////////////////////////
    // pin levels and reset values
    localparam logic LINE_IDLE      = 1'b1;
    localparam logic START_LEVEL    = 1'b0;
    localparam logic CTS_ASSERTED   = 1'b0;
    localparam logic CTS_DEASSERTED = 1'b1;
    localparam logic RESET_ACTIVE   = 1'b0;
    localparam logic LED_RESET      = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // flow control detection states
    typedef enum logic [1:0]
    {
        FC_IDLE,
        FC_DETECT,
        FC_ON,
        FC_OFF
    } flow_state_type;

    // bit period in cycles, never faster than the top baud rate
    function automatic logic [15:0] bit_cycles(input logic [15:0] div);
        return (div < MIN_BIT_CYCLES) ? MIN_BIT_CYCLES : div;
    endfunction

endpackage

// ### rtl/stream_if.sv
// valid/ready byte stream inside the bridge
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;

    modport src
    (
        output data,
        output valid,
        input  ready
    );

    modport snk
    (
        input  data,
        input  valid,
        output ready
    );
endinterface

// ### rtl/byte_fifo.sv
// first-in first-out buffer with a registered output stage
// assumes DEPTH is a power of two; holds DEPTH words plus one
`timescale 1ns/100ps
module byte_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // streams
    stream_if.snk    in_s,
    stream_if.src    out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic [WIDTH-1:0]            out_data;
        logic                        out_valid;
        logic                        in_ready;
    } fifo_state_type;

    fifo_state_type s_reg;
    fifo_state_type s_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic push;
        logic pop;
        logic load;
        s_next = s_reg;
        push   = in_s.valid && s_reg.in_ready;
        pop    = s_reg.out_valid && out_s.ready;
        load   = (!s_reg.out_valid || pop) && (s_reg.count != '0);
        if (pop)
            s_next.out_valid = 1'b0;
        if (load)
        begin
            s_next.out_data  = s_reg.mem[s_reg.rd_ptr];
            s_next.out_valid = 1'b1;
            s_next.rd_ptr    = s_reg.rd_ptr + 1'b1;
        end
        if (push)
        begin
            s_next.mem[s_reg.wr_ptr] = in_s.data;
            s_next.wr_ptr            = s_reg.wr_ptr + 1'b1;
        end
        unique case ({push, load})
            2'b10:   s_next.count = s_reg.count + 1'b1;
            2'b01:   s_next.count = s_reg.count - 1'b1;
            default: s_next.count = s_reg.count;
        endcase
        // ready drops once every slot is taken
        s_next.in_ready = s_next.count < (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg          <= '0;
            s_reg.in_ready <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign in_s.ready  = s_reg.in_ready;
    assign out_s.data  = s_reg.out_data;
    assign out_s.valid = s_reg.out_valid;
endmodule

// ### rtl/serial_receiver.sv
// asynchronous serial receiver, 8 data bits, no parity, one stop bit
// assumes the line input is already synchronous to the clock
`timescale 1ns/100ps
module serial_receiver
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // control
    input  wire logic        enable_i,
    input  wire logic [15:0] bit_cycles_i,
    // line
    input  wire logic        rxd_i,
    // received data
    output logic             start_o,
    output logic [7:0]       data_o,
    output logic             valid_o
);
    typedef struct packed
    {
        logic        busy;
        logic [15:0] tick;
        logic [3:0]  bit_idx;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic        valid;
        logic        start;
    } rx_state_type;

    rx_state_type s_reg;
    rx_state_type s_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [15:0] period;
        period       = vcom_pkg::bit_cycles(bit_cycles_i);
        s_next       = s_reg;
        s_next.valid = 1'b0;
        s_next.start = 1'b0;
        if (!enable_i)
            s_next.busy = 1'b0;
        else if (!s_reg.busy)
        begin
            if (rxd_i == vcom_pkg::START_LEVEL)
            begin
                // first sample lands mid start bit
                s_next.busy    = 1'b1;
                s_next.start   = 1'b1;
                s_next.tick    = period >> 1;
                s_next.bit_idx = '0;
            end
        end
        else if (s_reg.tick != '0)
            s_next.tick = s_reg.tick - 1'b1;
        else
        begin
            s_next.tick    = period - 1'b1;
            s_next.bit_idx = s_reg.bit_idx + 1'b1;
            if (s_reg.bit_idx == '0)
            begin
                if (rxd_i != vcom_pkg::START_LEVEL)
                    s_next.busy = 1'b0;
            end
            else if (s_reg.bit_idx == vcom_pkg::STOP_BIT_IDX)
            begin
                s_next.busy = 1'b0;
                if (rxd_i == vcom_pkg::LINE_IDLE)
                begin
                    s_next.data  = s_reg.shift;
                    s_next.valid = 1'b1;
                end
            end
            else
                s_next.shift = {rxd_i, s_reg.shift[7:1]};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign start_o = s_reg.start;
    assign data_o  = s_reg.data;
    assign valid_o = s_reg.valid;
endmodule

// ### rtl/vcom_bridge_flow_detect.sv
// serial bridge between a host terminal and a target uart, with automatic
// hardware flow control detection, target reset, bootloader entry and the
// drag-and-drop drive setting
// assumes all inputs are synchronous to CORE_CLK_I; the setting store
// outside keeps NV_DRIVE_EN_O across power cycles and returns it on
// NV_DRIVE_EN_I; RST_I is the power-on reset
`timescale 1ns/100ps

// Operation
// R1: button press resets the target; target must enable its pin reset.
// R2: button held at power-up enters bootloader mode, status led blinks.
// R3: baud rate configurable up to 1 Mbps; 921600 need not work.
// R4: lines cross over: target rts to cts, txd to rxd, both ways.
// R5: serial pins toward target stay high impedance until a terminal opens.
// R6: host asserts dtr before the bridge configures its serial pins.
// R7: every dtr assertion restarts flow control detection.
// R8: during detection drive target cts; sample target rts on first data.
// R9: target rts high means no flow control; rts and cts released.
// R10: detected flow control keeps target cts driven until reset or dtr.
// R11: target reuses rts and cts as io only without flow control.
// R12: alternate interface firmware gives no hardware flow control.
// R13: hex image written to the drive is programmed into the target.
// R14: drive enable or disable commands apply after next power cycle.
// R15: target reset held for the whole press, released on button release.
module vcom_bridge_flow_detect
#(
    parameter int BLINK_CYCLES = vcom_pkg::BLINK_CYCLES
)
(
    // clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_I,
    // host terminal side
    input  wire logic        HOST_DTR_I,
    input  wire logic [15:0] BAUD_DIV_I,
    input  wire logic        ALT_FIRMWARE_I,
    input  wire logic [7:0]  HOST_TX_DATA_I,
    input  wire logic        HOST_TX_VALID_I,
    output logic             HOST_TX_READY_O,
    output logic [7:0]       HOST_RX_DATA_O,
    output logic             HOST_RX_VALID_O,
    input  wire logic        HOST_RX_READY_I,
    // target uart pins
    input  wire logic        TGT_TXD_I,
    input  wire logic        TGT_RTS_I,
    output logic             TGT_RXD_O,
    output logic             TGT_RXD_OE_O,
    output logic             TGT_CTS_O,
    output logic             TGT_CTS_OE_O,
    // button, target reset and status led
    input  wire logic        BOOT_RESET_BUTTON_N_I,
    output logic             TGT_RESET_N_O,
    output logic             TGT_RESET_N_OE_O,
    output logic             BOOTLOADER_O,
    output logic             BRIDGE_STATUS_LED_O,
    // drag-and-drop drive
    input  wire logic        NV_DRIVE_EN_I,
    input  wire logic        DRIVE_ENABLE_CMD_I,
    input  wire logic        DRIVE_DISABLE_CMD_I,
    input  wire logic        IMAGE_DONE_I,
    output logic             NV_DRIVE_EN_O,
    output logic             DRAG_DROP_DRIVE_EN_O,
    output logic             PROG_START_O
);
    typedef struct packed
    {
        vcom_pkg::flow_state_type fc_state;
        logic                     dtr_d;
        logic                     tx_busy;
        logic [9:0]               tx_shift;
        logic [3:0]               tx_bit_idx;
        logic [15:0]              tx_tick;
        logic                     txd;
        logic                     txd_oe;
        logic                     cts;
        logic                     cts_oe;
        logic [7:0]               rx_hold;
        logic                     rx_hold_valid;
        logic                     rst_oe;
        logic                     por_done;
        logic                     boot_mode;
        logic [31:0]              blink_cnt;
        logic                     led;
        logic                     drive_en;
        logic                     drive_pending;
        logic                     prog_start;
    } bridge_state_type;

    bridge_state_type s_reg;
    bridge_state_type s_next;

    stream_if #(.W(vcom_pkg::DATA_W)) host_tx_s ();
    stream_if #(.W(vcom_pkg::DATA_W)) fifo_out_s ();

    logic       opened;
    logic       tx_pop;
    logic       rx_start;
    logic [7:0] rx_data;
    logic       rx_valid;

    ////////////////////////////////////////////////////////////////////////
    // host to target buffer
    assign host_tx_s.data  = HOST_TX_DATA_I;
    assign host_tx_s.valid = HOST_TX_VALID_I;
    assign fifo_out_s.ready = tx_pop;

    byte_fifo
    #(
        .WIDTH (vcom_pkg::DATA_W),
        .DEPTH (vcom_pkg::FIFO_DEPTH)
    )
    tx_fifo
    (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .in_s  (host_tx_s),
        .out_s (fifo_out_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // target to host receiver
    serial_receiver rx_core
    (
        .clk_i        (CORE_CLK_I),
        .rst_i        (RST_I),
        .enable_i     (opened),
        .bit_cycles_i (BAUD_DIV_I),
        .rxd_i        (TGT_TXD_I), // R4
        .start_o      (rx_start),
        .data_o       (rx_data),
        .valid_o      (rx_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // terminal open and transmit start
    assign opened = HOST_DTR_I && s_reg.por_done && !s_reg.boot_mode; // R6

    // with flow control on, target rts gates each new byte
    always_comb
    begin
        tx_pop = 1'b0;
        if (opened && fifo_out_s.valid && !s_reg.tx_busy)
        begin
            unique case (s_reg.fc_state)
                vcom_pkg::FC_DETECT: tx_pop = 1'b1;
                vcom_pkg::FC_OFF:    tx_pop = 1'b1;
                vcom_pkg::FC_ON:     tx_pop = TGT_RTS_I == 1'b0; // R4
                vcom_pkg::FC_IDLE:   tx_pop = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [15:0] period;
        logic        first_data;
        period            = vcom_pkg::bit_cycles(BAUD_DIV_I); // R3
        first_data        = tx_pop || rx_start;
        s_next            = s_reg;
        s_next.dtr_d      = HOST_DTR_I;
        s_next.prog_start = 1'b0;

        // power-up capture of button and stored drive setting
        if (!s_reg.por_done)
        begin
            s_next.por_done      = 1'b1;
            s_next.boot_mode     = !BOOT_RESET_BUTTON_N_I; // R2
            s_next.drive_en      = NV_DRIVE_EN_I; // R14
            s_next.drive_pending = NV_DRIVE_EN_I;
        end

        // flow control detection
        unique case (s_reg.fc_state)
            vcom_pkg::FC_IDLE,
            vcom_pkg::FC_ON,
            vcom_pkg::FC_OFF:
            begin
                if (opened && !s_reg.dtr_d)
                    s_next.fc_state = ALT_FIRMWARE_I ? vcom_pkg::FC_OFF
                                                     : vcom_pkg::FC_DETECT; // R7 R12
                else if (!opened && s_reg.fc_state == vcom_pkg::FC_OFF)
                    s_next.fc_state = vcom_pkg::FC_IDLE;
            end
            vcom_pkg::FC_DETECT:
            begin
                if (!opened)
                    s_next.fc_state = vcom_pkg::FC_IDLE;
                else if (first_data)
                    s_next.fc_state = TGT_RTS_I ? vcom_pkg::FC_OFF
                                                : vcom_pkg::FC_ON; // R8 R9
            end
        endcase

        // target cts drive
        unique case (s_next.fc_state)
            vcom_pkg::FC_DETECT:
            begin
                s_next.cts_oe = 1'b1; // R8
                s_next.cts    = vcom_pkg::CTS_ASSERTED;
            end
            vcom_pkg::FC_ON:
            begin
                // kept driven even after the terminal closes
                s_next.cts_oe = 1'b1; // R10
                s_next.cts    = s_reg.rx_hold_valid ? vcom_pkg::CTS_DEASSERTED
                                                    : vcom_pkg::CTS_ASSERTED;
            end
            default:
            begin
                s_next.cts_oe = 1'b0; // R5 R9
                s_next.cts    = vcom_pkg::CTS_DEASSERTED;
            end
        endcase

        // transmitter toward the target
        s_next.txd_oe = opened; // R5
        if (!opened)
        begin
            s_next.tx_busy = 1'b0;
            s_next.txd     = vcom_pkg::LINE_IDLE;
        end
        else if (tx_pop)
        begin
            s_next.tx_busy    = 1'b1;
            s_next.tx_shift   = {vcom_pkg::LINE_IDLE, fifo_out_s.data,
                                 vcom_pkg::START_LEVEL};
            s_next.tx_bit_idx = '0;
            s_next.tx_tick    = period - 1'b1;
            s_next.txd        = vcom_pkg::START_LEVEL; // R4
        end
        else if (s_reg.tx_busy)
        begin
            if (s_reg.tx_tick != '0)
                s_next.tx_tick = s_reg.tx_tick - 1'b1;
            else if (s_reg.tx_bit_idx == vcom_pkg::STOP_BIT_IDX)
                s_next.tx_busy = 1'b0;
            else
            begin
                s_next.tx_tick    = period - 1'b1;
                s_next.tx_bit_idx = s_reg.tx_bit_idx + 1'b1;
                s_next.tx_shift   = {vcom_pkg::LINE_IDLE,
                                     s_reg.tx_shift[9:1]};
                s_next.txd        = s_reg.tx_shift[1];
            end
        end

        // received bytes toward the host
        if (s_reg.rx_hold_valid && HOST_RX_READY_I)
            s_next.rx_hold_valid = 1'b0;
        if (rx_valid && (!s_reg.rx_hold_valid || HOST_RX_READY_I))
        begin
            s_next.rx_hold       = rx_data;
            s_next.rx_hold_valid = 1'b1;
        end
        if (!opened)
            s_next.rx_hold_valid = 1'b0;

        // target reset follows the button for the whole press, except in bootloader mode
        s_next.rst_oe = s_reg.por_done && !s_reg.boot_mode
                        && !BOOT_RESET_BUTTON_N_I; // R1 R15

        // status led blinks in bootloader mode
        if (s_reg.boot_mode)
        begin
            if (s_reg.blink_cnt >= 32'(BLINK_CYCLES - 1))
            begin
                s_next.blink_cnt = '0;
                s_next.led       = !s_reg.led; // R2
            end
            else
                s_next.blink_cnt = s_reg.blink_cnt + 1'b1;
        end
        else
            s_next.led = s_reg.por_done;

        // drive setting applies after the next power cycle
        if (s_reg.por_done)
        begin
            if (DRIVE_ENABLE_CMD_I)
                s_next.drive_pending = 1'b1; // R14
            else if (DRIVE_DISABLE_CMD_I)
                s_next.drive_pending = 1'b0; // R14
        end

        // a finished image starts target programming, except in bootloader mode
        s_next.prog_start = IMAGE_DONE_I && s_reg.drive_en
                            && !s_reg.boot_mode; // R13
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            s_reg          <= '0;
            s_reg.fc_state <= vcom_pkg::FC_IDLE;
            s_reg.txd      <= vcom_pkg::LINE_IDLE;
            s_reg.cts      <= vcom_pkg::CTS_DEASSERTED;
            s_reg.led      <= vcom_pkg::LED_RESET;
        end
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign HOST_TX_READY_O      = host_tx_s.ready;
    assign HOST_RX_DATA_O       = s_reg.rx_hold;
    assign HOST_RX_VALID_O      = s_reg.rx_hold_valid;
    assign TGT_RXD_O            = s_reg.txd;
    assign TGT_RXD_OE_O         = s_reg.txd_oe;
    assign TGT_CTS_O            = s_reg.cts;
    assign TGT_CTS_OE_O         = s_reg.cts_oe;
    assign TGT_RESET_N_O        = vcom_pkg::RESET_ACTIVE;
    assign TGT_RESET_N_OE_O     = s_reg.rst_oe;
    assign BOOTLOADER_O         = s_reg.boot_mode;
    assign BRIDGE_STATUS_LED_O  = s_reg.led;
    assign NV_DRIVE_EN_O        = s_reg.drive_pending;
    assign DRAG_DROP_DRIVE_EN_O = s_reg.drive_en;
    assign PROG_START_O         = s_reg.prog_start;
endmodule

// ### test/vcom_bridge_flow_detect_sva.sv
// port-level checker bound onto the bridge top
// assumes only the top ports; a second reset may come at any time
`timescale 1ns/100ps
module vcom_bridge_checker
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // host and target lines
    input wire logic HOST_DTR_I,
    input wire logic ALT_FIRMWARE_I,
    input wire logic TGT_RXD_OE_O,
    input wire logic TGT_CTS_O,
    input wire logic TGT_CTS_OE_O,
    // button and drive
    input wire logic BOOT_RESET_BUTTON_N_I,
    input wire logic TGT_RESET_N_OE_O,
    input wire logic BOOTLOADER_O,
    input wire logic DRIVE_ENABLE_CMD_I,
    input wire logic IMAGE_DONE_I,
    input wire logic NV_DRIVE_EN_O,
    input wire logic DRAG_DROP_DRIVE_EN_O,
    input wire logic PROG_START_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////////////////
    sequence s_open;
        $rose(HOST_DTR_I) && !BOOTLOADER_O && !$past(RST_I);
    endsequence
    sequence s_image;
        IMAGE_DONE_I && DRAG_DROP_DRIVE_EN_O && !BOOTLOADER_O
            ##1 !IMAGE_DONE_I;
    endsequence
    property p_btn_press;
        !BOOT_RESET_BUTTON_N_I && !BOOTLOADER_O && !$past(RST_I)
            |=> TGT_RESET_N_OE_O;
    endproperty
    a_btn_press: assert property (p_btn_press)
        else $error("reset not pulled");
    property p_btn_release;
        BOOT_RESET_BUTTON_N_I |=> !TGT_RESET_N_OE_O;
    endproperty
    a_btn_release: assert property (p_btn_release)
        else $error("reset held");
    property p_tri_idle;
        !HOST_DTR_I |=> !TGT_RXD_OE_O;
    endproperty
    a_tri_idle: assert property (p_tri_idle)
        else $error("txd driven");
    property p_dtr_open;
        s_open ##0 !ALT_FIRMWARE_I
            |=> TGT_CTS_OE_O && !TGT_CTS_O && TGT_RXD_OE_O;
    endproperty
    a_dtr_open: assert property (p_dtr_open)
        else $error("no detect");
    property p_alt_fw;
        s_open ##0 ALT_FIRMWARE_I |=> !TGT_CTS_OE_O;
    endproperty
    a_alt_fw: assert property (p_alt_fw)
        else $error("cts driven");
    property p_drive_cmd;
        DRIVE_ENABLE_CMD_I && !$past(RST_I) |=> NV_DRIVE_EN_O;
    endproperty
    a_drive_cmd: assert property (p_drive_cmd)
        else $error("enable not stored");
    property p_drive_live;
        !$past(RST_I, 2) |-> $stable(DRAG_DROP_DRIVE_EN_O);
    endproperty
    a_drive_live: assert property (p_drive_live)
        else $error("drive changed");
    property p_prog;
        s_image |-> PROG_START_O ##1 !PROG_START_O;
    endproperty
    a_prog: assert property (p_prog)
        else $error("bad prog pulse");
endmodule

bind vcom_bridge_flow_detect vcom_bridge_checker u_checker
(
    .CORE_CLK_I, .RST_I, .HOST_DTR_I, .ALT_FIRMWARE_I, .TGT_RXD_OE_O,
    .TGT_CTS_O, .TGT_CTS_OE_O, .BOOT_RESET_BUTTON_N_I, .TGT_RESET_N_OE_O,
    .BOOTLOADER_O, .DRIVE_ENABLE_CMD_I, .IMAGE_DONE_I, .NV_DRIVE_EN_O,
    .PROG_START_O, .DRAG_DROP_DRIVE_EN_O
);

// ### test/target_uart_model.sv
// behavioural target uart beyond the bridge
// assumes BIT clocks per bit; rts level is set by the bench
`timescale 1ns/100ps
module target_uart_model
#(
    parameter int BIT = 200
)
(
    input  wire logic clk_i,
    input  wire logic rxd_i,
    input  wire logic rxd_oe_i,
    input  wire logic rts_level_i,
    output logic      txd_o,
    output logic      rts_o
);
    logic [7:0] shift;
    logic [7:0] last_byte;
    int         rx_count = 0;
    initial txd_o = 1'b1;
    assign rts_o = rts_level_i;
    // bridge txd lands on our rxd, lsb first
    always
    begin
        @(posedge clk_i iff (rxd_oe_i && !rxd_i));
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk_i);
            shift[i] = rxd_i;
        end
        repeat (BIT) @(posedge clk_i);
        if (rxd_i)
        begin
            last_byte = shift;
            rx_count++;
        end
    end
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_i);
            txd_o = frame[i];
            repeat (BIT - 1) @(negedge clk_i);
        end
    endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the bridge top
// assumes the target model on the far side and a 200 MHz clock
`timescale 1ns/100ps
module testbench;
    logic clk, rst, dtr, alt, txv, rxr, btn_n, nv_in, en_c, dis_c, led0;
    logic img, rts_lvl, tx_rdy, rx_v, t_rxd, t_rxd_oe, cts, cts_oe;
    logic t_txd, t_rts, rst_n_o, rst_oe, boot, led, nv_o, dd_en, prog;
    logic [7:0] tx_b;
    logic [7:0] rx_b;
    int         bad_count;
    int         n_compared;
    int         n, k;
    typedef struct packed { logic en; logic dis; logic nv; } row_type;
    row_type rows [4] = '{3'h5, 3'h2, 3'h7, 3'h1};

    vcom_bridge_flow_detect #(.BLINK_CYCLES(8)) dut
    (
        .CORE_CLK_I(clk), .RST_I(rst), .HOST_DTR_I(dtr),
        .BAUD_DIV_I(16'h00c8), .ALT_FIRMWARE_I(alt), .HOST_TX_DATA_I(tx_b),
        .HOST_TX_VALID_I(txv), .HOST_TX_READY_O(tx_rdy),
        .HOST_RX_DATA_O(rx_b), .HOST_RX_VALID_O(rx_v),
        .HOST_RX_READY_I(rxr), .TGT_TXD_I(t_txd), .TGT_RTS_I(t_rts),
        .TGT_RXD_O(t_rxd), .TGT_RXD_OE_O(t_rxd_oe), .TGT_CTS_O(cts),
        .TGT_CTS_OE_O(cts_oe), .BOOT_RESET_BUTTON_N_I(btn_n),
        .TGT_RESET_N_O(rst_n_o), .TGT_RESET_N_OE_O(rst_oe),
        .BOOTLOADER_O(boot), .BRIDGE_STATUS_LED_O(led),
        .NV_DRIVE_EN_I(nv_in), .DRIVE_ENABLE_CMD_I(en_c),
        .DRIVE_DISABLE_CMD_I(dis_c), .IMAGE_DONE_I(img),
        .NV_DRIVE_EN_O(nv_o), .DRAG_DROP_DRIVE_EN_O(dd_en),
        .PROG_START_O(prog)
    );
    target_uart_model partner
    (
        .clk_i(clk), .rxd_i(t_rxd), .rxd_oe_i(t_rxd_oe),
        .rts_level_i(rts_lvl), .txd_o(t_txd), .rts_o(t_rts)
    );

    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        bad_count += int'(got !== exp);
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        bad_count++;
        close_out;
    end

    initial
    begin
        {clk, rst, dtr, alt, txv, rxr, en_c, dis_c, img, btn_n, nv_in} = 11'h203;
        {rts_lvl, tx_b, bad_count, n_compared} = '0;
        tick(3);
        chk(8'({t_rxd_oe, cts_oe, rst_oe, tx_rdy, rx_v}), 8'h02);
        tick(2);
        rst = 1'b0;
        tick(2);
        chk(8'({boot, led}), 8'h01);
        $display("reset done");
        foreach (rows[i])
        begin
            {en_c, dis_c} = {rows[i].en, rows[i].dis};
            tick(1);
            {en_c, dis_c} = 2'h0;
            tick(1);
            chk(8'({nv_o, dd_en}), 8'({rows[i].nv, 1'b1}));
        end
        img = 1'b1;
        tick(1);
        img = 1'b0;
        chk(8'(prog), 8'h01);
        tick(1);
        chk(8'(prog), 8'h00);
        $display("rows done");
        btn_n = 1'b0;
        tick(1);
        chk(8'({rst_oe, rst_n_o}), 8'h02);
        tick(6);
        chk(8'(rst_oe), 8'h01);
        btn_n = 1'b1;
        tick(1);
        chk(8'(rst_oe), 8'h00);
        $display("button done");
        // bytes wait while closed
        txv = 1'b1;
        for (n = 0; n < 40 && tx_rdy; n++)
        begin
            tx_b = 8'(n + 48);
            tick(1);
        end
        txv = 1'b0;
        chk(8'(n), 8'h21);
        chk(8'(t_rxd_oe), 8'h00);
        dtr = 1'b1;
        tick(2);
        chk(8'({cts_oe, cts, t_rxd_oe}), 8'h05);
        for (k = 0; k < 9000 && partner.rx_count < 2; k++)
            tick(1);
        rts_lvl = 1'b1;
        n = partner.rx_count;
        tick(3000);
        chk(8'(partner.rx_count - n > 1), 8'h00);
        rts_lvl = 1'b0;
        for (k = 0; k < 80000 && partner.rx_count < 33; k++)
            tick(1);
        chk(8'(partner.rx_count), 8'h21);
        chk(partner.last_byte, 8'h50);
        dtr = 1'b0;
        tick(2);
        chk(8'({cts_oe, t_rxd_oe}), 8'h02);
        {alt, dtr} = 2'h3;
        tick(2);
        chk(8'(cts_oe), 8'h00);
        {alt, dtr} = 2'h0;
        $display("flow on done");
        tick(2);
        {rts_lvl, dtr} = 2'h3;
        tick(2);
        chk(8'(cts_oe), 8'h01);
        partner.send_byte(8'h96);
        for (k = 0; k < 400 && rx_v !== 1'b1; k++)
            tick(1);
        chk(8'({cts_oe, rx_v}), 8'h01);
        chk(rx_b, 8'h96);
        rxr = 1'b1;
        tick(1);
        rxr = 1'b0;
        chk(8'(rx_v), 8'h00);
        $display("flow off done");
        {btn_n, nv_in, rst} = 3'h1;
        tick(5);
        rst = 1'b0;
        tick(2);
        chk(8'({boot, dd_en, rst_oe}), 8'h04);
        led0 = led;
        for (k = 0; k < 20 && led === led0; k++)
            tick(1);
        chk(8'(k < 20), 8'h01);
        $display("boot done");
        close_out;
    end
endmodule
